// ===== core/uie_irq_dma_cfg.sv
/*
  interrupt enable mask and dma configuration register of a full-speed
  usb peripheral, reached through command codes and byte transfers.
  assumes the host strobes are one-cycle pulses synchronous to clk and
  that bus events arrive as one-cycle pulses from the serial engine.
*/
// Notes on behaviour
// - mask bits 23..10 enable programmable endpoints fourteen to one.
// - mask bit 9 enables control in endpoint interrupts.
// - mask bit 8 enables control out endpoint interrupts.
// - mask bit 6 enables the short packet interrupt.
// - mask bit 5 enables the 1 ms pseudo frame interrupt.
// - mask bit 4 enables the frame start interrupt.
// - mask bit 3 enables the end of transfer interrupt.
// - mask bit 2 enables the suspend interrupt.
// - mask bit 1 enables the resume interrupt.
// - mask bit 0 enables the bus reset interrupt.
// - dma config written by f0, read by f1, two bytes each.
// - dma transfers start or stop per the written configuration.
// - bus reset clears only the dma enable bit.
`timescale 1ns/1ps
`include "uie_defines.svh"

module uie_irq_dma_cfg
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // host command interface
  input  wire logic                  cmdValid,
  input  wire logic [7:0]            cmdByte,
  input  wire logic                  wrValid,
  input  wire logic [7:0]            wrByte,
  input  wire logic                  rdStrobe,
  output logic      [7:0]            rdData,
  output logic                       rdValid,
  // bus events from the serial engine
  input  wire logic [13:0]           endpointEvent,
  input  wire logic                  ctrlInEvent,
  input  wire logic                  ctrlOutEvent,
  input  wire logic                  shortPacketEvent,
  input  wire logic                  pseudoSofEvent,
  input  wire logic                  sofEvent,
  input  wire logic                  eotEvent,
  input  wire logic                  suspendEvent,
  input  wire logic                  resumeEvent,
  input  wire logic                  busResetEvent,
  // interrupt requests
  output logic      [`UIE_EVT_W-1:0] irqEvents,
  output logic                       irqAny,
  // register contents
  output logic      [`UIE_MASK_W-1:0] irqEnableMask,
  output logic      [`UIE_DMA_W-1:0] dmaConfig,
  output logic                       dmaEnable
);

  uie_pkg::uie_regs_t regs;
  uie_pkg::uie_regs_t next_regs;
  logic [`UIE_EVT_W-1:0] eventVec;
  logic                  lastByte;

  // --------------------------------------------------------------------
  // event vector, aligned with mask positions
  // --------------------------------------------------------------------
  always_comb
  begin
    eventVec = '0;
    eventVec[`UIE_EP_MSB:`UIE_EP_LSB] = endpointEvent;
    eventVec[`UIE_BIT_CTRL_IN]        = ctrlInEvent;
    eventVec[`UIE_BIT_CTRL_OUT]       = ctrlOutEvent;
    eventVec[`UIE_BIT_RSVD]           = 1'b0;
    eventVec[`UIE_BIT_SHORT]          = shortPacketEvent;
    eventVec[`UIE_BIT_PSOF]           = pseudoSofEvent;
    eventVec[`UIE_BIT_SOF]            = sofEvent;
    eventVec[`UIE_BIT_EOT]            = eotEvent;
    eventVec[`UIE_BIT_SUSP]           = suspendEvent;
    eventVec[`UIE_BIT_RESUME]         = resumeEvent;
    eventVec[`UIE_BIT_BUSRST]         = busResetEvent;
  end

  uie_event_gate u_gate
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .events    (eventVec),
    .enables   (regs.mask[`UIE_EVT_W-1:0]),
    .irqEvents (irqEvents)
  );

  assign irqAny = |irqEvents;

  // --------------------------------------------------------------------
  // command sequencer and registers
  // --------------------------------------------------------------------
  always_comb
  begin
    next_regs         = regs;
    next_regs.rdValid = 1'b0;
    lastByte          = 1'b0;
    if (cmdValid)
    begin
      // a new command always aborts a transfer in progress
      next_regs.byteIdx = 2'h0;
      unique case (cmdByte)
        `UIE_CMD_MASK_WR:
        begin
          next_regs.state = uie_pkg::ST_MASK_WR;
        end
        `UIE_CMD_MASK_RD:
        begin
          next_regs.state  = uie_pkg::ST_MASK_RD;
          next_regs.shadow = regs.mask;
        end
        `UIE_CMD_DMA_WR:
        begin
          next_regs.state = uie_pkg::ST_DMA_WR;
        end
        `UIE_CMD_DMA_RD:
        begin
          next_regs.state  = uie_pkg::ST_DMA_RD;
          next_regs.shadow = {16'h0000, regs.dmaCfg};
        end
        default:
        begin
          // codes of other blocks: this block stays out of the way
          next_regs.state = uie_pkg::ST_IDLE;
        end
      endcase
    end
    else
    begin
      unique case (regs.state)
        uie_pkg::ST_IDLE:
        begin
          next_regs.byteIdx = 2'h0;
        end
        uie_pkg::ST_MASK_WR:
        begin
          if (wrValid)
          begin
            next_regs.shadow[regs.byteIdx*8 +: 8] = wrByte;
            lastByte = (regs.byteIdx == `UIE_MASK_LAST);
            next_regs.byteIdx = regs.byteIdx + 2'h1;
            if (lastByte)
            begin
              // top byte is reserved; whatever arrives is dropped
              next_regs.mask  = {8'h00,
                                 next_regs.shadow[`UIE_EVT_W-1:0]};
              next_regs.state = uie_pkg::ST_IDLE;
            end
          end
        end
        uie_pkg::ST_DMA_WR:
        begin
          if (wrValid)
          begin
            next_regs.shadow[regs.byteIdx*8 +: 8] = wrByte;
            lastByte = (regs.byteIdx == `UIE_DMA_LAST);
            next_regs.byteIdx = regs.byteIdx + 2'h1;
            if (lastByte)
            begin
              // whole word commits at once, never half a config
              next_regs.dmaCfg = next_regs.shadow[`UIE_DMA_W-1:0];
              next_regs.state  = uie_pkg::ST_IDLE;
            end
          end
        end
        uie_pkg::ST_MASK_RD,
        uie_pkg::ST_DMA_RD:
        begin
          if (rdStrobe)
          begin
            next_regs.rdData  = regs.shadow[regs.byteIdx*8 +: 8];
            next_regs.rdValid = 1'b1;
            next_regs.byteIdx = regs.byteIdx + 2'h1;
            if (regs.state == uie_pkg::ST_MASK_RD)
              lastByte = (regs.byteIdx == `UIE_MASK_LAST);
            else
              lastByte = (regs.byteIdx == `UIE_DMA_LAST);
            if (lastByte)
              next_regs.state = uie_pkg::ST_IDLE;
          end
        end
        default:
        begin
          next_regs.state = uie_pkg::ST_IDLE;
        end
      endcase
    end
    // bus reset has the last word over the enable bit, even against a
    // host write landing in the same cycle
    if (busResetEvent)
      next_regs.dmaCfg[`UIE_DMA_EN_BIT] = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regs         <= '0;
      regs.state   <= uie_pkg::ST_IDLE;
      regs.mask    <= `UIE_MASK_RESET;
      regs.dmaCfg  <= `UIE_DMA_RESET;
    end
    else
      regs <= next_regs;
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign rdData        = regs.rdData;
  assign rdValid       = regs.rdValid;
  assign irqEnableMask = regs.mask;
  assign dmaConfig     = regs.dmaCfg;
  assign dmaEnable     = regs.dmaCfg[`UIE_DMA_EN_BIT];

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_irq_needs_enable: assert property (
    (irqEvents & ~$past(regs.mask[`UIE_EVT_W-1:0])) == 24'h00_0000)
    else $error("interrupt passed with its enable low");

  a_ep_irq_passes: assert property (
    ((endpointEvent & regs.mask[`UIE_EP_MSB:`UIE_EP_LSB]) != 14'h0000)
      |=> (irqEvents[`UIE_EP_MSB:`UIE_EP_LSB] ==
           ($past(endpointEvent) &
            $past(regs.mask[`UIE_EP_MSB:`UIE_EP_LSB]))))
    else $error("endpoint interrupt lost or misplaced");

  a_ctrl_in_irq: assert property (
    (ctrlInEvent && regs.mask[`UIE_BIT_CTRL_IN])
      |=> irqEvents[`UIE_BIT_CTRL_IN] && irqAny)
    else $error("control in interrupt not raised");

  a_ctrl_out_irq: assert property (
    (ctrlOutEvent && regs.mask[`UIE_BIT_CTRL_OUT])
      |=> irqEvents[`UIE_BIT_CTRL_OUT])
    else $error("control out interrupt not raised");

  a_rsvd_bit_dead: assert property (
    !irqEvents[`UIE_BIT_RSVD])
    else $error("reserved mask position raised an interrupt");

  a_bus_event_irq: assert property (
    (eventVec[`UIE_BIT_SHORT:`UIE_BIT_BUSRST] != 7'h00)
      |=> (irqEvents[`UIE_BIT_SHORT:`UIE_BIT_BUSRST] ==
           ($past(eventVec[`UIE_BIT_SHORT:`UIE_BIT_BUSRST]) &
            $past(regs.mask[`UIE_BIT_SHORT:`UIE_BIT_BUSRST]))))
    else $error("bus event interrupt does not follow its enable");

  a_dma_reset_clear: assert property (
    busResetEvent |=> !dmaEnable)
    else $error("bus reset left dma enabled");

  a_dma_others_kept: assert property (
    (busResetEvent && !(regs.state == uie_pkg::ST_DMA_WR && wrValid))
      |=> ((dmaConfig | 16'h0008) == ($past(dmaConfig) | 16'h0008)))
    else $error("bus reset disturbed other dma bits");

  a_dma_two_bytes: assert property (
    (cmdValid && cmdByte == `UIE_CMD_DMA_WR)
      ##1 (wrValid && !cmdValid)
      ##1 (wrValid && !cmdValid && !busResetEvent)
      |=> (dmaConfig == {$past(wrByte), $past(wrByte, 2)})
          && regs.state == uie_pkg::ST_IDLE)
    else $error("dma write did not commit two bytes");

  a_read_answer: assert property (
    (rdStrobe && !cmdValid && (regs.state == uie_pkg::ST_DMA_RD ||
                               regs.state == uie_pkg::ST_MASK_RD))
      |=> rdValid ##1 !rdValid || $past(rdStrobe))
    else $error("read strobe not answered");

  a_dma_en_source: assert property (
    $changed(dmaEnable)
      |-> ($past(busResetEvent) ||
           ($past(wrValid) && !$past(cmdValid) &&
            $past(regs.state) == uie_pkg::ST_DMA_WR)))
    else $error("dma enable moved without a write or bus reset");

  a_mask_top_zero: assert property (
    irqEnableMask[31:24] == 8'h00)
    else $error("reserved mask byte holds ones");

  c_dma_write: cover property (
    (cmdValid && cmdByte == `UIE_CMD_DMA_WR) ##1 wrValid ##1 wrValid);

  c_mask_read: cover property (
    (cmdValid && cmdByte == `UIE_CMD_MASK_RD) ##1 rdStrobe[*4]);

  c_reset_clears: cover property (
    dmaEnable ##1 busResetEvent ##1 !dmaEnable);

  c_irq_seen: cover property (irqAny);

endmodule // uie_irq_dma_cfg

// ===== core/uie_defines.svh
/*
  command codes, field positions, reset values and byte counts of the
  interrupt enable mask and the dma configuration register.
  assumes it is included by bare name from the design files.
*/
`ifndef UIE_DEFINES_SVH
`define UIE_DEFINES_SVH

// ----------------------------------------------------------------------
// command codes on the parallel interface
// ----------------------------------------------------------------------
`define UIE_CMD_DMA_WR   8'hf0
`define UIE_CMD_DMA_RD   8'hf1
// mask codes: arbitrary values
`define UIE_CMD_MASK_WR  8'ha0
`define UIE_CMD_MASK_RD  8'ha1

// ----------------------------------------------------------------------
// byte counts, as index of the last byte
// ----------------------------------------------------------------------
`define UIE_MASK_LAST    2'h3
`define UIE_DMA_LAST     2'h1

// ----------------------------------------------------------------------
// interrupt enable mask fields
// ----------------------------------------------------------------------
`define UIE_MASK_W       32
`define UIE_EVT_W        24
`define UIE_EP_LSB       10
`define UIE_EP_MSB       23
`define UIE_BIT_CTRL_IN  9
`define UIE_BIT_CTRL_OUT 8
`define UIE_BIT_RSVD     7
`define UIE_BIT_SHORT    6
`define UIE_BIT_PSOF     5
`define UIE_BIT_SOF      4
`define UIE_BIT_EOT      3
`define UIE_BIT_SUSP     2
`define UIE_BIT_RESUME   1
`define UIE_BIT_BUSRST   0
`define UIE_MASK_RESET   32'h0000_0000

// ----------------------------------------------------------------------
// dma configuration fields
// ----------------------------------------------------------------------
`define UIE_DMA_W        16
`define UIE_DMA_EN_BIT   3
`define UIE_DMA_RESET    16'h0000

`endif

// ===== core/uie_pkg.sv
/*
  types shared by the interrupt enable / dma configuration block.
  assumes uie_defines.svh is on the include path.
*/
`include "uie_defines.svh"

package uie_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_MASK_WR = 3'b001,
    ST_MASK_RD = 3'b010,
    ST_DMA_WR  = 3'b011,
    ST_DMA_RD  = 3'b100
  } uie_state_t;

  typedef struct packed {
    uie_state_t             state;
    logic [1:0]             byteIdx;
    logic [`UIE_MASK_W-1:0] shadow;
    logic [`UIE_MASK_W-1:0] mask;
    logic [`UIE_DMA_W-1:0]  dmaCfg;
    logic [7:0]             rdData;
    logic                   rdValid;
  } uie_regs_t;

  typedef struct packed {
    logic [`UIE_EVT_W-1:0] gated;
  } uie_gate_t;

endpackage

// ===== core/uie_event_gate.sv
/*
  per-bit gate of interrupt events by the enable mask, registered.
  assumes event pulses are synchronous to clk.
*/
`timescale 1ns/1ps
`include "uie_defines.svh"

module uie_event_gate
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // events and enables
  input  wire logic [`UIE_EVT_W-1:0] events,
  input  wire logic [`UIE_EVT_W-1:0] enables,
  // gated interrupt requests
  output logic      [`UIE_EVT_W-1:0] irqEvents
);

  uie_pkg::uie_gate_t regs;
  uie_pkg::uie_gate_t next_regs;
  logic [`UIE_EVT_W-1:0] gateIn;

  // --------------------------------------------------------------------
  // gate
  // --------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `UIE_EVT_W; i = i + 1)
    begin : g_bit
      if (i == `UIE_BIT_RSVD)
      begin : g_rsvd
        // reserved position never raises anything
        assign gateIn[i] = 1'b0;
      end
      else
      begin : g_live
        assign gateIn[i] = events[i] & enables[i];
      end
    end
  endgenerate

  always_comb
  begin
    next_regs       = regs;
    next_regs.gated = gateIn;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regs <= '0;
    else
      regs <= next_regs;
  end

  assign irqEvents = regs.gated;

endmodule // uie_event_gate

// ===== verif/uie_host_model.sv
/*
  behavioural host that issues commands and byte transfers to the block.
  assumes strobes are sampled on the rising edge of clk.
*/
`timescale 1ns/1ps
`include "uie_defines.svh"

module uie_host_model
(
  // clock
  input  wire logic       clk,
  // command port
  output logic            cmdValid,
  output logic [7:0]      cmdByte,
  output logic            wrValid,
  output logic [7:0]      wrByte,
  output logic            rdStrobe,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  // idle cycles between written bytes, for the slow case
  int gap = 0;

  initial
  begin
    cmdValid = 1'b0;
    cmdByte  = 8'h00;
    wrValid  = 1'b0;
    wrByte   = 8'h00;
    rdStrobe = 1'b0;
  end

  // ----------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk);
    #5;
  endtask

  task automatic send_cmd(input logic [7:0] code);
    step();
    cmdValid = 1'b1;
    cmdByte  = code;
    step();
    cmdValid = 1'b0;
    // released lines carry no stale value
    cmdByte  = ~code;
  endtask

  task automatic write_reg(input logic [7:0] code, input int last,
                           input logic [31:0] data);
    send_cmd(code);
    for (int i = 0; i <= last; i++)
    begin
      wrValid = 1'b1;
      wrByte  = data[8*i +: 8];
      step();
      // back to back bytes keep the strobe up rather than pulse it
      if (gap > 0 || i == last)
      begin
        wrValid = 1'b0;
        wrByte  = ~wrByte;
        repeat (gap) step();
      end
    end
  endtask

  task automatic write_mask(input logic [31:0] data);
    write_reg(`UIE_CMD_MASK_WR, 3, {8'h00, data[23:0]});
  endtask

  task automatic read_reg(input logic [7:0] code, input int last,
                          output logic [31:0] data, output logic ok);
    send_cmd(code);
    data = 32'h0000_0000;
    ok   = 1'b1;
    for (int i = 0; i <= last; i++)
    begin
      rdStrobe = 1'b1;
      step();
      data[8*i +: 8] = rdData;
      ok = ok & rdValid;
    end
    rdStrobe = 1'b0;
  endtask
endmodule // uie_host_model

// ===== verif/uie_irq_dma_cfg_tb.sv
/*
  self-checking bench of the interrupt enable mask and dma configuration.
  assumes the host model above and the design files of core/.
*/
`timescale 1ns/1ps
`include "uie_defines.svh"

module uie_irq_dma_cfg_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmdValid;
  logic [7:0]  cmdByte;
  logic        wrValid;
  logic [7:0]  wrByte;
  logic        rdStrobe;
  logic [7:0]  rdData;
  logic        rdValid;
  logic [23:0] evt = 24'h0;
  logic [23:0] irqEvents;
  logic        irqAny;
  logic [31:0] irqEnableMask;
  logic [15:0] dmaConfig;
  logic        dmaEnable;
  logic [31:0] rd;
  logic        ok;
  int          fails = 0;
  int          checked = 0;

  always #25 clk = ~clk;

  uie_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .wrValid(wrValid), .wrByte(wrByte), .rdStrobe(rdStrobe),
    .rdData(rdData), .rdValid(rdValid));

  uie_irq_dma_cfg DUT (.clk(clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .wrValid(wrValid), .wrByte(wrByte),
    .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
    .endpointEvent(evt[23:10]), .ctrlInEvent(evt[9]),
    .ctrlOutEvent(evt[8]), .shortPacketEvent(evt[6]),
    .pseudoSofEvent(evt[5]), .sofEvent(evt[4]), .eotEvent(evt[3]),
    .suspendEvent(evt[2]), .resumeEvent(evt[1]),
    .busResetEvent(evt[0]), .irqEvents(irqEvents), .irqAny(irqAny),
    .irqEnableMask(irqEnableMask), .dmaConfig(dmaConfig),
    .dmaEnable(dmaEnable));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one-cycle event burst, gated result seen the cycle after
  task automatic pulse(input logic [23:0] p, input logic [23:0] exp);
    @(posedge clk);
    #5 evt = p;
    @(posedge clk);
    #5 evt = 24'h0;
    check({8'h00, irqEvents}, {8'h00, exp});
    check({31'h0, irqAny}, {31'h0, |exp});
    @(posedge clk);
    #5 check({8'h00, irqEvents}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check(irqEnableMask, 32'h0);
    check({16'h0, dmaConfig}, 32'h0);
    check({8'h00, irqEvents}, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_mask_rw();
    host.gap = 2;
    host.write_mask(32'hff5a_c3a5);
    host.gap = 0;
    check(irqEnableMask, 32'h005a_c3a5);
    host.read_reg(`UIE_CMD_MASK_RD, 3, rd, ok);
    check(rd, 32'h005a_c3a5);
    check({31'h0, ok}, 32'h1);
    $display("test mask access done");
  endtask

  // each enable alone, every event fired: only its own bit passes, and nothing for reserved bit 7
  task automatic test_gating();
    logic [23:0] one;
    logic [23:0] want;
    for (int b = 0; b < 24; b++)
    begin
      one  = 24'h1 << b;
      want = (b == 7) ? 24'h0 : one;
      host.write_mask({8'h00, one});
      pulse(24'hff_ffff, want);
    end
    host.write_mask(32'h0);
    pulse(24'hff_ffff, 24'h0);
    $display("test gating done");
  endtask

  task automatic test_dma();
    host.write_reg(`UIE_CMD_DMA_WR, 1, 32'h0000_c35e);
    check({16'h0, dmaConfig}, 32'h0000_c35e);
    check({31'h0, dmaEnable}, 32'h1);
    host.read_reg(`UIE_CMD_DMA_RD, 1, rd, ok);
    check(rd, 32'h0000_c35e);
    check({31'h0, ok}, 32'h1);
    // partial write cut short by a new command commits nothing
    host.write_reg(`UIE_CMD_DMA_WR, 0, 32'h0000_0000);
    // foreign code aborts too, and its bytes land nowhere
    host.write_reg(8'h55, 1, 32'h0000_ffff);
    host.read_reg(`UIE_CMD_DMA_RD, 1, rd, ok);
    check(rd, 32'h0000_c35e);
    $display("test dma config done");
  endtask

  task automatic test_bus_reset();
    host.write_mask(32'h0000_0001);
    pulse(24'h00_0001, 24'h00_0001);
    check({16'h0, dmaConfig}, 32'h0000_c356);
    check({31'h0, dmaEnable}, 32'h0);
    host.write_reg(`UIE_CMD_DMA_WR, 1, 32'h0000_0008);
    check({31'h0, dmaEnable}, 32'h1);
    $display("test bus reset done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    #5 reset_n = 1'b1;
    test_reset();
    test_mask_rw();
    test_gating();
    test_dma();
    test_bus_reset();
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("run limit reached at %0t", $time);
    print_verdict();
  end
endmodule // uie_irq_dma_cfg_tb
